// ===== evtstat_defs.vh
// Purpose: Constants for the event pin status block.
// Assumes: Wishbone classic slave with 32-bit data, byte addresses.
// Notes:   Flags and configuration enables are active low, as on the pin.
`ifndef EVTSTAT_DEFS_VH
`define EVTSTAT_DEFS_VH

// Register byte addresses.
`define OFS_EVENT_STATUS  4'h0
`define OFS_EVENT_CONFIG  4'h4
`define OFS_IRQ_STATUS    4'h8
`define OFS_IRQ_ENABLE    4'hc
// The write-one-to-clear path of the interrupt status shares its offset.
`define OFS_IRQ_CLEAR     4'h8

// Field positions shared by status and configuration; the pin disable bit is in configuration only.
`define BIT_SINGLE_FIX    0
`define BIT_DOUBLE_ERR    1
`define BIT_READY         4
`define BIT_PIN_DISABLE   7

// Reset values, reserved-bit masks and the event count.
`define EVENT_STATUS_RST  8'hff
`define EVENT_CONFIG_RST  8'hff
`define IRQ_ENABLE_RST    3'h0
`define IRQ_STATUS_RST    3'h0
`define CONFIG_RSVD_ONES  8'h6c
`define RSVD_MASK         8'hec
`define NUM_EVENTS        3

// Bus state codes, one-hot.
`define ST_IDLE           2'h1
`define ST_ACK            2'h2

`endif

// ===== event_flag.v
// Purpose: One active-low sticky event flag.
// Assumes: Event and clear arrive as one-cycle pulses.
// Notes:   A new event in the clear cycle keeps the flag set.
`timescale 1ns/1ps

module event_flag (
    // Clock and reset
    input  wire CLK,
    input  wire RESETN,
    // Control
    input  wire ENABLE_N,
    input  wire EVENT,
    input  wire CLEAR,
    // State
    output wire FLAG_N
);
    reg flag_q;
    reg flag_d;

    always @* begin
        flag_d = flag_q;
        if (CLEAR) begin
            flag_d = 1'b1;
        end
        // Set wins over clear so no event is lost.
        if (EVENT && !ENABLE_N) begin
            flag_d = 1'b0;
        end
    end

    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            flag_q <= 1'b1;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign FLAG_N = flag_q;
endmodule // event_flag

// ===== event_pin_status_register.v
// Purpose: Event status register with open-drain event pin and Wishbone access.
// Assumes: Event inputs are one-cycle pulses synchronous to CORE_CLK.
// Notes:   Software interrupt bits mirror flag set events, separately maskable.
//
// Overview of operation
// RULE1 - Ready flag, bit 4, goes 0 after a busy-to-ready event drives the pin.
// RULE2 - Double-bit error flag, bit 1, goes 0 on an enabled detection.
// RULE3 - Single-bit fix flag, bit 0, goes 0 on an enabled correction.
// RULE4 - Host writes reserved bits 7:5 and 3:2 as ones.
// RULE5 - Flags stay occurred until the host clears them.
// RULE6 - A source disabled in the configuration never updates its flag.
// RULE7 - Disabling a source leaves its flag as it is.
// RULE8 - Event pin is open-drain active low, gated by the pin disable bit.
// RULE9 - Writing 1 clears a flag; pin releases once no enabled flag remains.
`timescale 1ns/1ps
`include "evtstat_defs.vh"

module event_pin_status_register (
    // Clock and reset
    input  wire        CORE_CLK,
    input  wire        RESETN,
    // Wishbone slave
    input  wire        WB_CYC_I,
    input  wire        WB_STB_I,
    input  wire        WB_WE_I,
    input  wire [3:0]  WB_ADR_I,
    input  wire [3:0]  WB_SEL_I,
    input  wire [31:0] WB_DAT_I,
    output reg  [31:0] WB_DAT_O,
    output wire        WB_ACK_O,
    output wire        WB_ERR_O,
    // Internal events
    input  wire        READY_EVENT,
    input  wire        DOUBLE_ERR_EVENT,
    input  wire        SINGLE_FIX_EVENT,
    // Event pin, open drain
    output wire        EVENT_PIN_O,
    output wire        EVENT_PIN_OE,
    // Software interrupt
    output wire        IRQ
);
    // Bus state and answer.
    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg         err_q;
    reg         err_d;
    reg  [31:0] dat_d;

    // Register contents.
    reg  [7:0]  config_q;
    reg  [7:0]  config_d;
    reg  [2:0]  irq_stat_q;
    reg  [2:0]  irq_stat_d;
    reg  [2:0]  irq_en_q;
    reg  [2:0]  irq_en_d;
    reg         pin_q;

    // Read path.
    reg  [31:0] rdata_d;
    reg         hit_d;

    // Request qualification and address decode.
    wire        req;
    wire        wr_lane0;
    wire        sel_status;
    wire        sel_config;
    wire        sel_irq_stat;
    wire        sel_irq_en;
    wire        sel_irq_clr;

    // Event and flag paths.
    wire [2:0]  ev_in;
    wire [2:0]  cfg_en_n;
    wire [2:0]  wr_bits;
    wire [2:0]  clr_flag;
    wire [2:0]  irq_clr;
    wire [2:0]  flag_n;
    wire [2:0]  flag_live;
    wire [7:0]  status_rd;
    wire        pin_low_d;

    // A request is only taken while idle, so a strobe held during the answer is ignored.
    assign req          = WB_CYC_I && WB_STB_I && state_q[0];
    assign wr_lane0     = req && WB_WE_I && WB_SEL_I[0];
    assign sel_status   = (WB_ADR_I == `OFS_EVENT_STATUS);
    assign sel_config   = (WB_ADR_I == `OFS_EVENT_CONFIG);
    assign sel_irq_stat = (WB_ADR_I == `OFS_IRQ_STATUS);
    assign sel_irq_en   = (WB_ADR_I == `OFS_IRQ_ENABLE);
    assign sel_irq_clr  = (WB_ADR_I == `OFS_IRQ_CLEAR);

    // Source bits in flag order: ready, double error, single fix.
    assign ev_in    = {READY_EVENT,
                       DOUBLE_ERR_EVENT,
                       SINGLE_FIX_EVENT};
    assign cfg_en_n = {config_q[`BIT_READY],
                       config_q[`BIT_DOUBLE_ERR],
                       config_q[`BIT_SINGLE_FIX]};
    assign wr_bits  = {WB_DAT_I[`BIT_READY],
                       WB_DAT_I[`BIT_DOUBLE_ERR],
                       WB_DAT_I[`BIT_SINGLE_FIX]};

    // Writing a one clears; a zero leaves the flag alone.
    assign clr_flag = wr_bits & {`NUM_EVENTS{wr_lane0 && sel_status}}; // [RULE9]

    // Interrupt status bits sit in the low lane in source order.
    assign irq_clr  = WB_DAT_I[2:0] & {`NUM_EVENTS{wr_lane0 && sel_irq_clr}};

    // One flag per event source; the configuration gates setting only.
    genvar i;
    generate
        for (i = 0; i < `NUM_EVENTS; i = i + 1) begin : g_flag
            event_flag u_flag (
                .CLK      (CORE_CLK),
                .RESETN   (RESETN),
                .ENABLE_N (cfg_en_n[i]), // [RULE6] [RULE7]
                .EVENT    (ev_in[i]),
                .CLEAR    (clr_flag[i]), // [RULE5]
                .FLAG_N   (flag_n[i])
            );
        end
    endgenerate

    // Reserved bits read as ones; host writes to them are ignored.
    assign status_rd = `RSVD_MASK | {3'h0, flag_n[2], 2'h0, flag_n[1], flag_n[0]}; // [RULE1] [RULE2] [RULE3]

    // Flags that are set and whose source may still drive the pin.
    assign flag_live = ~flag_n & ~cfg_en_n;

    // Only an enabled flag holds the pin low, so disabling releases it.
    assign pin_low_d = !config_q[`BIT_PIN_DISABLE] && (|flag_live); // [RULE8] [RULE9]

    // Configuration register next value.
    always @* begin
        config_d = config_q;
        if (wr_lane0 && sel_config) begin
            // Reserved bits are forced to ones so the enables never see junk there.
            config_d = WB_DAT_I[7:0] | `CONFIG_RSVD_ONES;
        end
    end

    // Interrupt enable next value.
    always @* begin
        irq_en_d = irq_en_q;
        if (wr_lane0 && sel_irq_en) begin
            irq_en_d = WB_DAT_I[2:0];
        end
    end

    // Interrupt status next value.
    always @* begin
        irq_stat_d = irq_stat_q & ~irq_clr;
        // Set wins over clear so an event in the clear cycle is not lost.
        irq_stat_d = irq_stat_d | (ev_in & ~cfg_en_n);
    end

    // Read data multiplexer; unused upper bits read as zero.
    always @* begin
        hit_d   = 1'b1;
        rdata_d = 32'h0;
        case (WB_ADR_I)
            `OFS_EVENT_STATUS: begin
                rdata_d[7:0] = status_rd;
            end
            `OFS_EVENT_CONFIG: begin
                rdata_d[7:0] = config_q;
            end
            `OFS_IRQ_STATUS: begin
                rdata_d[2:0] = irq_stat_q;
            end
            `OFS_IRQ_ENABLE: begin
                rdata_d[2:0] = irq_en_q;
            end
            default: begin
                hit_d = 1'b0;
            end
        endcase
    end

    // Bus answer sequencer: take in idle, answer in the next cycle.
    always @* begin
        state_d = state_q;
        err_d   = err_q;
        dat_d   = WB_DAT_O;
        case (state_q)
            `ST_IDLE: begin
                if (req) begin
                    state_d = `ST_ACK;
                    err_d   = !hit_d;
                    dat_d   = WB_WE_I ? 32'h0 : rdata_d;
                end
            end
            `ST_ACK: begin
                state_d = `ST_IDLE;
            end
            default: begin
                state_d = `ST_IDLE;
            end
        endcase
    end

    // Bus state and read data.
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q  <= `ST_IDLE;
            err_q    <= 1'b0;
            WB_DAT_O <= 32'h0;
        end else begin
            state_q  <= state_d;
            err_q    <= err_d;
            WB_DAT_O <= dat_d;
        end
    end

    // Software visible registers.
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            config_q   <= `EVENT_CONFIG_RST;
            irq_stat_q <= `IRQ_STATUS_RST;
            irq_en_q   <= `IRQ_ENABLE_RST;
        end else begin
            config_q   <= config_d;
            irq_stat_q <= irq_stat_d;
            irq_en_q   <= irq_en_d;
        end
    end

    // The pin enable is registered so the pad never sees decode glitches.
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_low_d;
        end
    end

    // Answer one cycle after the request; unmapped addresses get err.
    assign WB_ACK_O     = state_q[1] && !err_q;
    assign WB_ERR_O     = state_q[1] && err_q;
    assign EVENT_PIN_O  = 1'b0;
    assign EVENT_PIN_OE = pin_q; // [RULE8]
    assign IRQ          = |(irq_stat_q & irq_en_q);
endmodule // event_pin_status_register

// ===== evt_chk_assertions.sv
// Purpose: Checker for the event pin status block.
// Assumes: Bound to the top module, sees its ports only.
// Notes: Only software can release the pin, so a release must follow a write.
`timescale 1ns/1ps
module evt_chk (
    input wire       CORE_CLK, RESETN, WB_CYC_I, WB_STB_I,
    input wire       WB_ACK_O, WB_ERR_O, EVENT_PIN_O, EVENT_PIN_OE,
    input wire [3:0] WB_ADR_I
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
    ack_timing_a: assert property ($rose(WB_STB_I) |=> WB_ACK_O || WB_ERR_O)
        else $error("no answer");
    err_addr_a: assert property (WB_ERR_O |-> WB_ADR_I[1:0] != 2'h0) else $error("bad err");
    ack_addr_a: assert property (WB_ACK_O |-> WB_ADR_I[1:0] == 2'h0) else $error("bad ack");
    answer_excl_a: assert property (!(WB_ACK_O && WB_ERR_O)) else $error("ack and err");
    ack_req_a: assert property (WB_ACK_O || WB_ERR_O |-> WB_CYC_I && WB_STB_I)
        else $error("answer without request");
    pin_low_a: assert property (EVENT_PIN_OE |-> !EVENT_PIN_O) else $error("pin drives high");
    pin_release_a: assert property ($fell(EVENT_PIN_OE) |-> $past(WB_ACK_O) || $past(WB_ACK_O, 2))
        else $error("pin released without write");
    cover property (EVENT_PIN_OE);
    cover property (WB_ERR_O);
    cover property ($fell(EVENT_PIN_OE));
endmodule // evt_chk
bind event_pin_status_register evt_chk chk_i (.*);

// ===== pin_pull.sv
// Purpose: Board side of the open-drain event pin.
// Assumes: A pull-up holds the line high when released.
// Notes: None.
`timescale 1ns/1ps
module pin_pull (input wire o, input wire oe, output wire pin);
    assign pin = oe ? o : 1'b1;
endmodule // pin_pull

// ===== tb.sv
// Purpose: Random self-checking bench against a flag model.
// Assumes: Events are pulsed while the bus is idle.
// Notes: Reserved bits of the status and configuration registers are written as ones.
`timescale 1ns/1ps
module tb;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
    logic [3:0] adr = 0;
    logic [31:0] dat = 0, q;
    logic [2:0] ev = 0;
    logic ack, err, po, poe, irq, pin, e;
    logic [7:0] st = 8'hff, cfg = 8'hff, irs = 0, ien = 0, d, x, v;
    logic [15:0] r = 16'h0024;
    int error_cnt = 0, tests_run = 0, n;
    event_pin_status_register uut (.CORE_CLK(clk), .RESETN(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat),
        .WB_DAT_O(q), .WB_ACK_O(ack), .WB_ERR_O(err), .READY_EVENT(ev[2]),
        .DOUBLE_ERR_EVENT(ev[1]), .SINGLE_FIX_EVENT(ev[0]), .EVENT_PIN_O(po),
        .EVENT_PIN_OE(poe), .IRQ(irq));
    pin_pull pp (.o(po), .oe(poe), .pin(pin));
    initial forever #2.5 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task chk(input [31:0] g, input [31:0] x0);
        tests_run++;
        if (g !== x0) begin
            $display("unexpected at %0t: got %h exp %h", $time, g, x0);
            error_cnt++;
        end
    endtask
    task results;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task wb(input w, input [3:0] a, input [7:0] v);
        int i;
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, v};
        for (i = 0; i < 20 && !(ack === 1 || err === 1); i++) @(posedge clk);
        if (i == 20) begin
            chk(0, 1);
            results();
        end
        e = err;
        x = q[7:0];
        cyc <= 0; stb <= 0;
        @(posedge clk);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        for (n = 0; n < 400; n++) begin
            r = lfsr(r);
            d = r[15:8];
            if (r[1:0] == 0) begin
                ev <= r[6:4];
                @(posedge clk);
                ev <= 0;
                st &= ~({3'h0, r[6], 2'h0, r[5:4]} & ~cfg);
                irs |= r[6:4] & ~{cfg[4], cfg[1:0]};
            end else if (r[1:0] == 1) begin
                v = d | (r[3:2] == 0 ? 8'hec : r[3:2] == 1 ? 8'h6c : 8'h00);
                wb(1, {r[3:2], 2'h0}, v);
                case (r[3:2])
                    0: st |= v & 8'h13;
                    1: cfg = v;
                    2: irs &= ~v[2:0];
                    3: ien = {5'h0, v[2:0]};
                endcase
            end else begin
                wb(0, {r[3:2], 1'b0, r[1] & r[0]}, 0);
                chk(e, r[0]);
                if (!r[0]) chk(x, r[3:2] == 0 ? st : r[3:2] == 1 ? cfg : r[3:2] == 3 ? ien : irs);
            end
            repeat (3) @(posedge clk);
            chk(pin, !(|(~st & ~cfg & 8'h13) && !cfg[7]));
            chk(irq, |(irs & ien));
        end
        results();
    end
endmodule // tb
